/* File: shared/dio_pkg.sv */
// constants, register map and types of the rear panel digital I/O port
package dio_pkg;
    // ==========================================================
    // port geometry
    localparam int NUM_PINS = 7;
    localparam int PIN_CLEAR = 0;
    localparam int PIN_PROT_STATE = 1;
    localparam int PIN_TRIGGER = 3;
    localparam int PIN_INHIBIT = 4;
    // ==========================================================
    // timing
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int PWM_TICK_NS = 1000;
    localparam int PWM_TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * PWM_TICK_NS / 1000;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] FUNC_SEL_OFS = 8'h00;
    localparam logic [7:0] INVERT_OFS = 8'h04;
    localparam logic [7:0] OUT_VALUE_OFS = 8'h08;
    localparam logic [7:0] PWM_ENABLE_OFS = 8'h0C;
    localparam logic [7:0] PWM_PERIOD_OFS = 8'h10;
    localparam logic [7:0] PWM_DUTY_OFS = 8'h14;
    localparam logic [7:0] INPUT_LEVEL_OFS = 8'h18;
    localparam logic [7:0] EDGE_EVENT_OFS = 8'h1C;
    localparam logic [7:0] CONTROL_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;
    // ==========================================================
    // fields and reset values
    localparam int PERIOD_W = 16;
    localparam int DUTY_W = 7;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
    localparam logic [1:0] FUNC_CODE_INPUT = 2'h1;
    localparam logic [1:0] FUNC_CODE_OUTPUT = 2'h2;
    localparam int FAULT_ACTION_BIT = 0;
    localparam int STAT_PROT_BIT = 0;
    localparam int STAT_ZERO_BIT = 1;
    localparam int STAT_OFF_BIT = 2;
    localparam logic [2*NUM_PINS-1:0] FUNC_SEL_RST = 14'h0000;
    localparam logic [PERIOD_W-1:0] PWM_PERIOD_RST = 16'h2710;
    localparam logic [DUTY_W-1:0] PWM_DUTY_RST = 7'h0A;
    // ==========================================================
    // types
    typedef enum logic [1:0] {FUNC_SPECIAL, FUNC_INPUT, FUNC_OUTPUT} pin_func_t;
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage : dio_pkg

/* File: shared/pwm_if.sv */
// carrier between the port logic and the shared pwm generator
`timescale 1ns/1ps
interface pwm_if;
    logic [15:0] periodTicks;
    logic [6:0] dutyPct;
    logic pwmLow;
    modport gen (input periodTicks, input dutyPct, output pwmLow);
    modport user (output periodTicks, output dutyPct, input pwmLow);
endinterface : pwm_if

/* File: hw/pwm_gen.sv */
// pwm generator shared by all pins, period in microsecond ticks
`timescale 1ns/1ps
module pwm_gen
    import dio_pkg::*;
#(
    parameter int TICK_CYCLES = PWM_TICK_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // settings and waveform
    pwm_if.gen pwm
);
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0] divCnt_q;
    logic tick_q;
    logic [PERIOD_W-1:0] phase_q;
    logic [PERIOD_W+DUTY_W-1:0] phaseScaled;
    logic [PERIOD_W+DUTY_W-1:0] lowLimit;

    // ==========================================================
    // microsecond enable pulse
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (divCnt_q == DIV_LAST)
        begin
            divCnt_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            divCnt_q <= divCnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // phase within the period
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_q <= '0;
        else if (tick_q)
        begin
            if (phase_q >= pwm.periodTicks - 1'b1 || pwm.periodTicks == '0)
                phase_q <= '0;
            else
                phase_q <= phase_q + 1'b1;
        end
    end

    // low while phase/period is below duty/100
    assign phaseScaled = (PERIOD_W+DUTY_W)'(phase_q) * (PERIOD_W+DUTY_W)'(DUTY_FULL);
    assign lowLimit = (PERIOD_W+DUTY_W)'(pwm.periodTicks) * (PERIOD_W+DUTY_W)'(pwm.dutyPct);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            pwm.pwmLow <= 1'b0;
        else
            pwm.pwmLow <= (pwm.periodTicks != '0) && (phaseScaled < lowLimit);
    end

    // a period shortened under a running phase is allowed one wrap
    AST_PHASE_RANGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pwm.periodTicks != '0 && $stable(pwm.periodTicks) && phase_q < pwm.periodTicks)
        ##1 $stable(pwm.periodTicks) |-> phase_q < pwm.periodTicks)
        else $error("pwm phase ran past the period");
endmodule : pwm_gen

/* File: hw/dio_port.sv */
// seven pin digital I/O port with Avalon-MM register access
`timescale 1ns/1ps
module dio_port
    import dio_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // terminal pins
    input wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOe,
    // supply control
    input wire logic protTrip,
    output logic protectionStateOut,
    output logic supplyForceZero,
    output logic supplyOutputOff,
    output logic listTrigger,
    output logic dlogTrigger
);
    // ==========================================================
    // helpers
    function automatic pin_func_t funcOf(input logic [2*NUM_PINS-1:0] sel, input int idx);
        logic [1:0] code;
        code = sel[2*idx +: 2];
        case (code)
            FUNC_CODE_INPUT: funcOf = FUNC_INPUT;
            FUNC_CODE_OUTPUT: funcOf = FUNC_OUTPUT;
            default: funcOf = FUNC_SPECIAL;
        endcase
    endfunction : funcOf

    function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[8*b +: 8] = wd[8*b +: 8];
        beMerge = res;
    endfunction : beMerge

    // ==========================================================
    // state
    bus_state_t busState_q;
    logic [2*NUM_PINS-1:0] funcSel_q;
    logic [NUM_PINS-1:0] invert_q;
    logic [NUM_PINS-1:0] outValue_q;
    logic [NUM_PINS-1:0] pwmEnable_q;
    logic [PERIOD_W-1:0] pwmPeriod_q;
    logic [DUTY_W-1:0] pwmDuty_q;
    logic faultAction_q;
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] sync2_q;
    logic [NUM_PINS-1:0] inputLevel_q;
    logic [NUM_PINS-1:0] edgeEvent_q;
    logic [NUM_PINS-1:0] levelNow;
    logic [NUM_PINS-1:0] fall;
    logic [31:0] rdMux;
    logic writeFire;
    logic clearPulse;
    logic trigPulse;
    logic faultNow;
    pwm_if pwmBus();

    assign writeFire = (busState_q == BUS_ANSWER) && avs_write;

    // ==========================================================
    // bus slave: one wait cycle, then answer
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busState_q <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            case (busState_q)
                BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        busState_q <= BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rdMux : 32'h00000000;
                    end
                end
                BUS_ANSWER:
                begin
                    busState_q <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    busState_q <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        rdMux = 32'h00000000;
        case (avs_address)
            FUNC_SEL_OFS: rdMux = 32'(funcSel_q);
            INVERT_OFS: rdMux = 32'(invert_q);
            OUT_VALUE_OFS: rdMux = 32'(outValue_q);
            PWM_ENABLE_OFS: rdMux = 32'(pwmEnable_q);
            PWM_PERIOD_OFS: rdMux = 32'(pwmPeriod_q);
            PWM_DUTY_OFS: rdMux = 32'(pwmDuty_q);
            INPUT_LEVEL_OFS: rdMux = 32'(inputLevel_q);
            EDGE_EVENT_OFS: rdMux = 32'(edgeEvent_q);
            CONTROL_OFS: rdMux = 32'(faultAction_q);
            STATUS_OFS: rdMux = 32'({supplyOutputOff, supplyForceZero, protectionStateOut});
            default: rdMux = 32'h00000000;
        endcase
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            funcSel_q <= FUNC_SEL_RST;
            invert_q <= '0;
            outValue_q <= '0;
            pwmEnable_q <= '0;
            pwmPeriod_q <= PWM_PERIOD_RST;
            pwmDuty_q <= PWM_DUTY_RST;
            faultAction_q <= 1'b0;
        end
        else if (writeFire)
        begin
            case (avs_address)
                FUNC_SEL_OFS:
                    funcSel_q <= 14'(beMerge(32'(funcSel_q), avs_writedata, avs_byteenable));
                INVERT_OFS:
                    invert_q <= 7'(beMerge(32'(invert_q), avs_writedata, avs_byteenable));
                OUT_VALUE_OFS:
                    outValue_q <= 7'(beMerge(32'(outValue_q), avs_writedata, avs_byteenable));
                PWM_ENABLE_OFS:
                    pwmEnable_q <= 7'(beMerge(32'(pwmEnable_q), avs_writedata, avs_byteenable));
                PWM_PERIOD_OFS:
                    pwmPeriod_q <= 16'(beMerge(32'(pwmPeriod_q), avs_writedata, avs_byteenable));
                PWM_DUTY_OFS:
                    pwmDuty_q <= 7'(beMerge(32'(pwmDuty_q), avs_writedata, avs_byteenable));
                CONTROL_OFS:
                    faultAction_q <= avs_byteenable[0] ? avs_writedata[FAULT_ACTION_BIT]
                                                       : faultAction_q;
                default:
                    faultAction_q <= faultAction_q;
            endcase
        end
    end

    // ==========================================================
    // input sampling, polarity and falling edges
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
        end
        else
        begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
        end
    end

    assign levelNow = sync2_q ^ invert_q;
    assign fall = inputLevel_q & ~levelNow;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            inputLevel_q <= '1;
        else
            inputLevel_q <= levelNow;
    end

    // sticky edge events, write one to clear, new edge wins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            edgeEvent_q <= '0;
        else if (writeFire && avs_address == EDGE_EVENT_OFS && avs_byteenable[0])
            edgeEvent_q <= (edgeEvent_q & ~avs_writedata[NUM_PINS-1:0]) | fall;
        else
            edgeEvent_q <= edgeEvent_q | fall;
    end

    // ==========================================================
    // special functions
    assign clearPulse = (funcOf(funcSel_q, PIN_CLEAR) == FUNC_SPECIAL) && fall[PIN_CLEAR];
    assign trigPulse = (funcOf(funcSel_q, PIN_TRIGGER) == FUNC_SPECIAL) && fall[PIN_TRIGGER];
    assign faultNow = (funcOf(funcSel_q, PIN_INHIBIT) == FUNC_SPECIAL) && !levelNow[PIN_INHIBIT];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            protectionStateOut <= 1'b0;
        else if (protTrip)
            protectionStateOut <= 1'b1;
        else if (clearPulse)
            protectionStateOut <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            supplyForceZero <= 1'b0;
            supplyOutputOff <= 1'b0;
        end
        else
        begin
            supplyForceZero <= faultNow && !faultAction_q;
            supplyOutputOff <= faultNow && faultAction_q;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            listTrigger <= 1'b0;
            dlogTrigger <= 1'b0;
        end
        else
        begin
            listTrigger <= trigPulse;
            dlogTrigger <= trigPulse;
        end
    end

    // ==========================================================
    // pwm generator
    assign pwmBus.periodTicks = pwmPeriod_q;
    assign pwmBus.dutyPct = pwmDuty_q;

    pwm_gen #(.TICK_CYCLES(PWM_TICK_CYCLES)) u_pwm (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pwm(pwmBus.gen)
    );

    // ==========================================================
    // pin drivers, same general I/O on every pin
    sequence seqClear;
        clearPulse && !protTrip;
    endsequence

    sequence seqTrigger;
        trigPulse ##1 (listTrigger && dlogTrigger);
    endsequence

    AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (busState_q == BUS_IDLE && (avs_read || avs_write))
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after exactly one wait cycle");

    AST_IN_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $stable(invert_q) |-> inputLevel_q == ($past(pinIn, 3) ^ $past(invert_q)))
        else $error("reported input level does not follow the synchronised pin");

    AST_PROT_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        seqClear |=> !protectionStateOut)
        else $error("protection not cleared by pulse");

    AST_TRIG_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        seqTrigger |=> !listTrigger)
        else $error("trigger pulse not one cycle");

    AST_FAULT_ACTION: assert property (@(posedge sys_clk) disable iff (!reset_n)
        faultNow |=> (supplyForceZero != supplyOutputOff)
            && (supplyOutputOff == $past(faultAction_q)))
        else $error("fault reaction does not match the setting");

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_pin
            pin_func_t pinFunc;
            logic logicTrue;
            logic drive;
            assign pinFunc = funcOf(funcSel_q, gi);
            always_comb
            begin
                logicTrue = 1'b0;
                drive = 1'b0;
                case (pinFunc)
                    FUNC_OUTPUT:
                    begin
                        drive = 1'b1;
                        logicTrue = pwmEnable_q[gi] ? pwmBus.pwmLow : outValue_q[gi];
                    end
                    FUNC_SPECIAL:
                    begin
                        drive = (gi == PIN_PROT_STATE);
                        logicTrue = (gi == PIN_PROT_STATE) && protectionStateOut;
                    end
                    default:
                    begin
                        drive = 1'b0;
                        logicTrue = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    pinOut[gi] <= 1'b1;
                    pinOe[gi] <= 1'b0;
                end
                else
                begin
                    pinOe[gi] <= drive;
                    pinOut[gi] <= ~logicTrue ^ invert_q[gi];
                end
            end

            AST_OUT_NORMAL: assert property (@(posedge sys_clk) disable iff (!reset_n)
                (pinFunc == FUNC_OUTPUT && !pwmEnable_q[gi] && !invert_q[gi])
                |=> pinOe[gi] && (pinOut[gi] == !$past(outValue_q[gi])))
                else $error("normal output level wrong");

            AST_OUT_INVERT: assert property (@(posedge sys_clk) disable iff (!reset_n)
                (pinFunc == FUNC_OUTPUT && !pwmEnable_q[gi] && invert_q[gi])
                |=> pinOut[gi] == $past(outValue_q[gi]))
                else $error("inverted output level wrong");

            AST_PWM_FOLLOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
                (pinFunc == FUNC_OUTPUT && pwmEnable_q[gi] && !invert_q[gi])
                |=> pinOut[gi] == !$past(pwmBus.pwmLow))
                else $error("pwm output does not follow the generator");

            AST_IN_INVERT: assert property (@(posedge sys_clk) disable iff (!reset_n)
                ($past(invert_q[gi]) && $stable(invert_q[gi]))
                |-> inputLevel_q[gi] != $past(pinIn[gi], 3))
                else $error("inverted input not complemented");

            AST_EDGE_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
                fall[gi] |=> edgeEvent_q[gi])
                else $error("falling edge not recorded");

            AST_SPECIAL_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
                (pinFunc == FUNC_SPECIAL && gi != PIN_PROT_STATE) |=> !pinOe[gi])
                else $error("special input pin is driven");
        end
    endgenerate
endmodule : dio_port

/* File: test/ext_instrument.sv */
// model of the external instrument wired to the rear terminal
`timescale 1ns/1ps
module ext_instrument
    import dio_pkg::*;
(
    // design side of each pin
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOe,
    // instrument sink switches, high pulls a released pin low
    input wire logic [NUM_PINS-1:0] pullLow,
    // resolved terminal level
    output logic [NUM_PINS-1:0] pinLevel
);
    // ==========================================================
    // wire resolution
    // released pins float up to the pull-up, so an open pin reads high
    // instrument only sinks, so its pulses are high to low transitions
    always_comb
    begin
        pinLevel = (pinOe & pinOut) | (~pinOe & ~pullLow);
    end
endmodule : ext_instrument

/* File: test/testbench.sv */
// self-checking bench for the rear panel digital I/O port
`timescale 1ns/1ps
module testbench;
    import dio_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [NUM_PINS-1:0] extLow = 7'h00;
    logic [NUM_PINS-1:0] pinLevel;
    logic [NUM_PINS-1:0] pinOut;
    logic [NUM_PINS-1:0] pinOe;
    logic protTrip = 1'b0;
    logic protectionStateOut;
    logic supplyForceZero;
    logic supplyOutputOff;
    logic listTrigger;
    logic dlogTrigger;
    int listCount = 0;
    int dlogCount = 0;
    int listBase;
    int dlogBase;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int lowCount;

    dio_port uut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe),
        .protTrip(protTrip), .protectionStateOut(protectionStateOut),
        .supplyForceZero(supplyForceZero), .supplyOutputOff(supplyOutputOff),
        .listTrigger(listTrigger), .dlogTrigger(dlogTrigger));

    ext_instrument partner (.pinOut(pinOut), .pinOe(pinOe), .pullLow(extLow),
        .pinLevel(pinLevel));

    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // trigger capture and hang guard
    always @(posedge sys_clk)
    begin
        if (listTrigger === 1'b1)
            listCount++;
        if (dlogTrigger === 1'b1)
            dlogCount++;
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    // ==========================================================
    // tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // waitrequest sampled low ends this wait; the hang guard ends a stuck one
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rdchk

    // instrument pulls one pin low for three cycles
    task automatic pulse(input int p);
        @(posedge sys_clk);
        extLow[p] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        extLow[p] <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : pulse

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        check({25'h0, pinOe}, 32'h0);
        rdchk(FUNC_SEL_OFS, 32'h0);
        rdchk(PWM_PERIOD_OFS, 32'h2710);
        rdchk(PWM_DUTY_OFS, 32'h0A);
        rdchk(8'h30, 32'h0);
        $display("reset values done");
        wr(FUNC_SEL_OFS, 32'h1555);
        repeat (4) @(posedge sys_clk);
        rdchk(INPUT_LEVEL_OFS, 32'h7F);
        extLow <= 7'h04;
        repeat (4) @(posedge sys_clk);
        rdchk(INPUT_LEVEL_OFS, 32'h7B);
        rdchk(EDGE_EVENT_OFS, 32'h04);
        wr(EDGE_EVENT_OFS, 32'h04);
        rdchk(EDGE_EVENT_OFS, 32'h0);
        extLow <= 7'h00;
        wr(INVERT_OFS, 32'h7F);
        repeat (4) @(posedge sys_clk);
        rdchk(INPUT_LEVEL_OFS, 32'h0);
        check({25'h0, pinOe}, 32'h0);
        $display("input test done");
        wr(INVERT_OFS, 32'h0);
        wr(OUT_VALUE_OFS, 32'h55);
        wr(FUNC_SEL_OFS, 32'h2AAA);
        repeat (2) @(posedge sys_clk);
        check({25'h0, pinOut}, 32'h2A);
        check({25'h0, pinOe}, 32'h7F);
        wr(INVERT_OFS, 32'h7F);
        repeat (2) @(posedge sys_clk);
        check({25'h0, pinOut}, 32'h55);
        $display("output test done");
        wr(FUNC_SEL_OFS, 32'h2);
        wr(PWM_PERIOD_OFS, 32'h0A);
        wr(PWM_DUTY_OFS, 32'h1E);
        wr(PWM_ENABLE_OFS, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            wr(INVERT_OFS, {31'h0, k[0]});
            repeat (300) @(posedge sys_clk);
            lowCount = 0;
            repeat (250)
            begin
                @(posedge sys_clk);
                if (pinOut[0] === 1'b0)
                    lowCount++;
            end
            check(lowCount, (k == 0) ? 32'h4B : 32'hAF);
        end
        $display("pwm test done");
        wr(PWM_ENABLE_OFS, 32'h0);
        wr(INVERT_OFS, 32'h0);
        wr(FUNC_SEL_OFS, 32'h0);
        // let edges from the mode change pass before tripping
        repeat (4) @(posedge sys_clk);
        protTrip <= 1'b1;
        @(posedge sys_clk);
        protTrip <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(protectionStateOut, 32'h1);
        check(pinOut[1], 32'h0);
        rdchk(STATUS_OFS, 32'h1);
        pulse(PIN_CLEAR);
        check(protectionStateOut, 32'h0);
        listBase = listCount;
        dlogBase = dlogCount;
        pulse(PIN_TRIGGER);
        check(listCount - listBase, 32'h1);
        check(dlogCount - dlogBase, 32'h1);
        extLow <= 7'h10;
        repeat (6) @(posedge sys_clk);
        check(supplyForceZero, 32'h1);
        rdchk(STATUS_OFS, 32'h2);
        extLow <= 7'h00;
        repeat (6) @(posedge sys_clk);
        check(supplyForceZero, 32'h0);
        wr(CONTROL_OFS, 32'h1);
        extLow <= 7'h10;
        repeat (6) @(posedge sys_clk);
        check(supplyOutputOff, 32'h1);
        check(supplyForceZero, 32'h0);
        $display("special function test done");
        give_verdict();
    end
endmodule : testbench
